// *** mrod_defs.svh ***
// Field positions and encodings for the opcode field decoder
`ifndef MROD_DEFS_SVH
`define MROD_DEFS_SVH
`define MROD_FMT_HI      21
`define MROD_FMT_LO      20
`define MROD_LONG_BIT    12
`define MROD_OP_HI       19
`define MROD_OP_LO       13
`define MROD_DEST_HI     31
`define MROD_DEST_LO     27
`define MROD_SRC2_HI     26
`define MROD_SRC2_LO     22
`define MROD_SRC1_HI     4
`define MROD_SRC1_LO     0
`define MROD_SHIFT_INV   11
`define MROD_SHIFT_ROT   10
`define MROD_MEM_SCALE   11
`define MROD_MEM_DIRECT  10
`define MROD_FLUSH_CLR   27
`define MROD_TRAP_EMU    27
`define MROD_ILL_CONST   12
`define MROD_V_ACC_HI    16
`define MROD_V_ACC_LO    11
`define MROD_V_ZERO      8
`define MROD_V_PREC      7
`define MROD_V_PPREC     9
`define MROD_V_MEM_HI    10
`define MROD_V_MEM_LO    6
`define MROD_F_PD        9
`define MROD_F_P2        7
`define MROD_F_P1        5
`define MROD_F_RM        7
`define MROD_OP_W        7'h00
`endif

// *** mrod_pkg.sv ***
// Types shared by the opcode field decoder
package mrod_pkg;
  typedef enum logic [1:0] {MROD_SZ_BYTE, MROD_SZ_HALF, MROD_SZ_WORD, MROD_SZ_DOUBLE} mrod_size_t;
  typedef enum logic [1:0] {MROD_RND_NEAR, MROD_RND_ZERO, MROD_RND_PINF, MROD_RND_MINF} mrod_round_t;
  typedef enum logic [1:0] {MROD_MASK_OFF, MROD_MASK_ON, MROD_MASK_INV} mrod_mask_t;
  typedef enum logic [1:0] {MROD_FILL_ZERO, MROD_FILL_MERGE, MROD_FILL_SIGN} mrod_fill_t;
  typedef enum logic [1:0] {MROD_LOG_AND, MROD_LOG_OR, MROD_LOG_XOR, MROD_LOG_XNOR} mrod_logic_t;
  typedef enum logic [3:0] {
    MROD_C_NONE, MROD_C_TRAP, MROD_C_CTRL, MROD_C_SHIFT, MROD_C_LOGIC, MROD_C_LOAD, MROD_C_STORE,
    MROD_C_FLUSH, MROD_C_BRANCH, MROD_C_INT, MROD_C_VEC, MROD_C_FP, MROD_C_BIT, MROD_C_ILLEGAL
  } mrod_class_t;
  typedef struct packed {
    mrod_class_t  op_class;
    logic [6:0]   opcode;
    logic [4:0]   dest;
    logic [4:0]   src2;
    logic [4:0]   src1;
    logic [31:0]  imm;
    logic         imm_valid;
    mrod_size_t   access_size_field;
    logic         writeback;
    logic         scale;
    logic         direct;
    logic [2:0]   scale_shift;
    mrod_mask_t   mask_mode;
    mrod_fill_t   fill_mode;
    logic         mask_invert;
    logic         rotate_sense;
    mrod_logic_t  logic_op;
    logic         invert_src1;
    logic         invert_src2;
    logic         flush_clear;
    logic         emu_trap;
    logic         annul;
    logic         vec_dp;
    logic         par_dp;
    logic         par_mem;
    logic [4:0]   par_reg;
    logic         acc_sel;
    logic         acc_zero;
    logic         accumulate;
    logic [1:0]   first_operand_precision;
    logic [1:0]   second_operand_precision;
    logic [1:0]   result_precision;
    mrod_round_t  round_select;
    logic         const_operands;
    logic         illegal;
  } mrod_ctrl_t;
endpackage

// *** mrod_shift_dec.sv ***
// Shift variant decoder: mask mode and fill mode
`include "mrod_defs.svh"
module mrod_shift_dec
  import mrod_pkg::*;
(
  input  wire logic [2:0] variant,
  output mrod_mask_t      mask_mode,
  output mrod_fill_t      fill_mode,
  output logic            bad
);
  // Eight variants: three masks by three fills, no sign fill with inverted mask
  always_comb begin
    mask_mode = MROD_MASK_OFF;
    fill_mode = MROD_FILL_ZERO;
    bad       = 1'b0;
    case (variant)
      3'h0: begin mask_mode = MROD_MASK_OFF; fill_mode = MROD_FILL_ZERO;  end
      3'h1: begin mask_mode = MROD_MASK_OFF; fill_mode = MROD_FILL_MERGE; end
      3'h2: begin mask_mode = MROD_MASK_OFF; fill_mode = MROD_FILL_SIGN;  end
      3'h3: begin mask_mode = MROD_MASK_ON;  fill_mode = MROD_FILL_ZERO;  end
      3'h4: begin mask_mode = MROD_MASK_ON;  fill_mode = MROD_FILL_MERGE; end
      3'h5: begin mask_mode = MROD_MASK_ON;  fill_mode = MROD_FILL_SIGN;  end
      3'h6: begin mask_mode = MROD_MASK_INV; fill_mode = MROD_FILL_ZERO;  end
      3'h7: begin mask_mode = MROD_MASK_INV; fill_mode = MROD_FILL_MERGE; end
      default: bad = 1'b1;
    endcase
  end
endmodule

// *** mrod_decoder.sv ***
// Opcode field decoder for long-immediate, three-register and miscellaneous formats
`include "mrod_defs.svh"
// What this block does
// - Size field 0 byte, 1 halfword, 2 word, 3 doubleword.
// - Modify bit on load, store or flush writes address back to base.
// - Scale bit multiplies offset by access size before adding base.
// - Direct bit flags access to bypass data cache.
// - Eight shift variants combine mask mode with fill mode.
// - Invert bit complements endmask; n bit selects rotation sense.
// - Cache flush flushes sub-block; F bit also clears present flags.
// - Trap passes emulation bit for emulation routing.
// - Long-immediate form takes next 32-bit word as operand.
// - Vector d bit selects destination single or double precision; multiply-accumulate forms always decode single.
// - Vector P bit sets parallel load/store precision.
// - Vector m bits give parallel memory operation on memory register.
// - Multiply-accumulate a bit selects accumulator; Z substitutes zero.
// - Scalar float takes separate precisions for both sources and result; convert/round forces second source precision to 0.
// - Convert/round mode: nearest, zero, plus infinity, minus infinity.
// - All-ones illegal opcode with C bit uses constant operands.
// - AND/OR suffix picks true or complemented sources; plus XOR, XNOR.
// - Vector multiply-accumulate adds product into selected accumulator.
// - Branch A bit annuls delay slot when taken.
module mrod_decoder
  import mrod_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        insn_valid,
  input  wire logic [31:0] insn,
  input  wire logic        imm_word_valid,
  input  wire logic [31:0] imm_word,
  output logic             insn_ready,
  output logic             ctrl_valid,
  output mrod_ctrl_t       ctrl
);
  typedef enum logic [1:0] {MROD_IDLE, MROD_WAIT_IMM} mrod_state_t;

  mrod_state_t state_reg;
  mrod_state_t state_next;
  logic [31:0] held_reg;
  mrod_ctrl_t  dec;
  mrod_ctrl_t  ctrl_reg;
  logic        ctrl_valid_reg;
  logic [31:0] cur;
  logic        fmt_ok;
  logic        long_form;
  logic [6:0]  opc;
  mrod_mask_t  sh_mask;
  mrod_fill_t  sh_fill;
  logic        sh_bad;
  logic        emit;

  // Instruction under decode: held word while the immediate is awaited
  assign cur       = (state_reg == MROD_WAIT_IMM) ? held_reg : insn;
  assign fmt_ok    = (cur[`MROD_FMT_HI:`MROD_FMT_LO] == 2'h3);
  assign long_form = fmt_ok && cur[`MROD_LONG_BIT];
  assign opc       = cur[`MROD_OP_HI:`MROD_OP_LO];

  mrod_shift_dec u_shift (
    .variant   (opc[2:0]),
    .mask_mode (sh_mask),
    .fill_mode (sh_fill),
    .bad       (sh_bad)
  );

  // Field decode for all opcode groups
  always_comb begin
    dec                   = '0;
    dec.opcode            = opc;
    dec.dest              = cur[`MROD_DEST_HI:`MROD_DEST_LO];
    dec.src2              = cur[`MROD_SRC2_HI:`MROD_SRC2_LO];
    dec.src1              = cur[`MROD_SRC1_HI:`MROD_SRC1_LO];
    dec.imm_valid         = long_form;
    dec.imm               = long_form ? imm_word : 32'h0000_0000;
    dec.op_class          = MROD_C_ILLEGAL;
    if (!fmt_ok) begin
      dec.op_class = MROD_C_ILLEGAL;
    end else if (opc[6:3] == 4'h0) begin
      case (opc[2:0])
        3'h1: begin
          dec.op_class = MROD_C_TRAP;
          dec.emu_trap = cur[`MROD_TRAP_EMU];
        end
        3'h2, 3'h4, 3'h5, 3'h6: dec.op_class = MROD_C_CTRL;
        default: dec.op_class = MROD_C_ILLEGAL;
      endcase
    end else if (opc[6:3] == 4'h1) begin
      dec.op_class     = sh_bad ? MROD_C_ILLEGAL : MROD_C_SHIFT;
      dec.mask_mode    = sh_mask;
      dec.fill_mode    = sh_fill;
      dec.mask_invert  = cur[`MROD_SHIFT_INV];
      dec.rotate_sense = cur[`MROD_SHIFT_ROT];
    end else if (opc[6:4] == 3'h1) begin
      dec.op_class = MROD_C_LOGIC;
      case (opc[3:0])
        4'h1: begin dec.logic_op = MROD_LOG_AND; end
        4'h2: begin dec.logic_op = MROD_LOG_AND; dec.invert_src1 = 1'b1; end
        4'h4: begin dec.logic_op = MROD_LOG_AND; dec.invert_src2 = 1'b1; end
        4'h8: begin dec.logic_op = MROD_LOG_AND; dec.invert_src1 = 1'b1; dec.invert_src2 = 1'b1; end
        4'h6: dec.logic_op = MROD_LOG_XOR;
        4'h9: dec.logic_op = MROD_LOG_XNOR;
        4'h7: begin dec.logic_op = MROD_LOG_OR; end
        4'hB: begin dec.logic_op = MROD_LOG_OR; dec.invert_src1 = 1'b1; end
        4'hD: begin dec.logic_op = MROD_LOG_OR; dec.invert_src2 = 1'b1; end
        4'hE: begin dec.logic_op = MROD_LOG_OR; dec.invert_src1 = 1'b1; dec.invert_src2 = 1'b1; end
        default: dec.op_class = MROD_C_ILLEGAL;
      endcase
    end else if (opc[6:5] == 2'h1 && opc[4:3] != 2'h3) begin
      // Load, unsigned load, store
      dec.op_class          = opc[4] ? MROD_C_STORE : MROD_C_LOAD;
      dec.access_size_field = mrod_size_t'(cur[14:13]);
      dec.writeback         = cur[15];
      dec.scale             = cur[`MROD_MEM_SCALE];
      dec.scale_shift       = cur[`MROD_MEM_SCALE] ? {1'b0, cur[14:13]} : 3'h0;
      dec.direct            = cur[`MROD_MEM_DIRECT];
    end else if (opc[6:3] == 4'h7 && opc[1:0] == 2'h0) begin
      dec.op_class    = MROD_C_FLUSH;
      dec.writeback   = cur[15];
      dec.flush_clear = cur[`MROD_FLUSH_CLR];
    end else if (opc[6:4] == 3'h4) begin
      // Branches: link, jump, bit tests, conditional; annul bit lowest
      dec.op_class = MROD_C_BRANCH;
      dec.annul    = opc[0];
      if (opc[3:1] == 3'h1 || opc[3:1] == 3'h3 || opc[3:1] == 3'h7) begin
        dec.op_class = MROD_C_ILLEGAL;
      end
    end else if (opc[6:4] == 3'h5) begin
      // Compare, add and subtract
      dec.op_class = MROD_C_INT;
      if (opc[3:0] != 4'h0 && opc[3:2] != 2'h2) begin
        dec.op_class = MROD_C_ILLEGAL;
      end
    end else if (opc[6:4] == 3'h6) begin
      // Vector group
      dec.op_class    = MROD_C_VEC;
      dec.vec_dp      = cur[`MROD_V_PREC];
      dec.par_dp      = cur[`MROD_V_PPREC];
      dec.par_mem     = cur[`MROD_V_MEM_HI] | cur[`MROD_V_MEM_LO];
      dec.par_reg     = cur[`MROD_DEST_HI:`MROD_DEST_LO];
      if (opc[2:1] == 2'h3 || opc[2:0] == 3'h3) begin
        dec.acc_sel    = cur[`MROD_V_ACC_HI] | cur[`MROD_V_ACC_LO];
        dec.acc_zero   = cur[`MROD_V_ZERO];
        dec.vec_dp     = 1'b0;
        dec.accumulate = (opc[2:1] == 2'h3);
      end
    end else if (opc[6:3] == 4'hE) begin
      dec.op_class                 = MROD_C_FP;
      dec.result_precision         = cur[10:9];
      dec.second_operand_precision = cur[8:7];
      dec.first_operand_precision  = cur[6:5];
      if (opc[2:0] == 3'h4) begin
        dec.round_select             = mrod_round_t'(cur[8:7]);
        dec.second_operand_precision = 2'h0;
      end
      if (opc[2:0] == 3'h6) begin
        dec.op_class = MROD_C_ILLEGAL;
      end
    end else if (opc == 7'h7F) begin
      dec.op_class       = MROD_C_ILLEGAL;
      dec.const_operands = cur[`MROD_ILL_CONST];
    end else if (opc == 7'h78 || opc == 7'h79 || opc == 7'h7E) begin
      dec.op_class = MROD_C_BIT;
    end else begin
      dec.op_class = MROD_C_ILLEGAL;
    end
    // Reserved bits are trusted to be zero, so only the class decides
    dec.illegal = (dec.op_class == MROD_C_ILLEGAL);
  end

  // Sequencing of the long-immediate word
  always_comb begin
    state_next = state_reg;
    emit       = 1'b0;
    insn_ready = 1'b0;
    case (state_reg)
      MROD_IDLE: begin
        insn_ready = 1'b1;
        if (insn_valid) begin
          if (long_form) begin
            if (imm_word_valid) begin
              emit = 1'b1;
            end else begin
              state_next = MROD_WAIT_IMM;
            end
          end else begin
            emit = 1'b1;
          end
        end
      end
      MROD_WAIT_IMM: begin
        if (imm_word_valid) begin
          emit       = 1'b1;
          state_next = MROD_IDLE;
        end
      end
      default: state_next = MROD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= MROD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Held instruction while awaiting the immediate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_reg <= 32'h0000_0000;
    end else if (state_reg == MROD_IDLE && insn_valid) begin
      held_reg <= insn;
    end
  end

  // Registered control output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg       <= '0;
      ctrl_valid_reg <= 1'b0;
    end else begin
      ctrl_valid_reg <= emit;
      if (emit) begin
        ctrl_reg <= dec;
      end
    end
  end

  assign ctrl       = ctrl_reg;
  assign ctrl_valid = ctrl_valid_reg;
endmodule

// *** mrod_fetch_model.sv ***
// Far-side model that supplies the long-immediate word, promptly or late
module mrod_fetch_model (
  input  wire logic        clk,
  input  wire logic        prompt,
  input  wire logic [2:0]  delay,
  input  wire logic [31:0] value,
  input  wire logic        insn_valid,
  input  wire logic [31:0] insn,
  input  wire logic        insn_ready,
  output logic             imm_word_valid,
  output logic [31:0]      imm_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        late_valid = 1'b0;
  logic        pending    = 1'b0;
  logic [2:0]  cnt        = 3'h0;
  logic [31:0] last       = 32'h0;
  logic        long_f;
  // Long form on the instruction lines
  assign long_f = insn_valid && insn[21:20] == 2'h3 && insn[12];
  // Word comes with the instruction or some cycles later
  assign imm_word_valid = prompt ? long_f : late_valid;
  // A withheld word shows the inverse of the last one
  assign imm_word = imm_word_valid ? value : ~last;
  // Count the delay down between edges
  always @(negedge clk) begin
    if (pending && cnt == 3'h0) late_valid <= 1'b1;
    else if (pending) cnt <= cnt - 3'h1;
  end
  // Word taken at the edge; new wait after a long form
  always @(posedge clk) begin
    if (imm_word_valid) last <= value;
    if (late_valid) begin
      late_valid <= 1'b0;
      pending    <= 1'b0;
    end else if (long_f && insn_ready && !prompt) begin
      pending <= 1'b1;
      cnt     <= delay;
    end
  end
endmodule

// *** mrod_decoder_asserts.sv ***
// Port-level checks for the opcode field decoder
module mrod_decoder_asserts
  import mrod_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        insn_valid,
  input wire logic [31:0] insn,
  input wire logic        imm_word_valid,
  input wire logic [31:0] imm_word,
  input wire logic        insn_ready,
  input wire logic        ctrl_valid,
  input wire mrod_ctrl_t  ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic       long_f;
  logic       take;
  logic       tk;
  logic       done;
  logic [6:0] op;
  // Instruction complete at this edge
  assign long_f = insn[21:20] == 2'h3 && insn[12];
  assign take   = insn_valid && insn_ready && (!long_f || imm_word_valid);
  assign tk     = take && insn[21:20] == 2'h3;
  assign done   = take || (!insn_ready && imm_word_valid);
  assign op     = insn[19:13];
  a_one_pulse: assert property (done |=> ctrl_valid)
    else $error("no answer after a complete instruction");
  a_no_extra: assert property (!done |=> !ctrl_valid)
    else $error("answer without a complete instruction");
  a_ctrl_holds: assert property (!ctrl_valid |-> $stable(ctrl))
    else $error("ctrl changed without a pulse");
  a_long_waits: assert property (insn_valid && insn_ready && long_f && !imm_word_valid |=> !insn_ready)
    else $error("long form did not wait for its word");
  a_imm_taken: assert property ((take && long_f) || (!insn_ready && imm_word_valid)
    |=> ctrl.imm == $past(imm_word) && ctrl.imm_valid)
    else $error("immediate word not carried");
  a_size_decode: assert property (tk && op[6:5] == 2'h1 && op[4:3] != 2'h3
    |=> ctrl.access_size_field == $past(insn[14:13]))
    else $error("size field wrong");
  a_modify_wb: assert property (tk && op[6:5] == 2'h1 && (op[4:3] != 2'h3 || op[1:0] == 2'h0)
    |=> ctrl.writeback == $past(insn[15]))
    else $error("writeback wrong");
  a_scale_dir: assert property (tk && op[6:5] == 2'h1 && op[4:3] != 2'h3
    |=> ctrl.scale == $past(insn[11]) && ctrl.direct == $past(insn[10])
    && ctrl.scale_shift == ($past(insn[11]) ? {1'b0, $past(insn[14:13])} : 3'h0))
    else $error("scale or direct wrong");
  a_shift_bits: assert property (tk && op[6:3] == 4'h1
    |=> ctrl.mask_invert == $past(insn[11]) && ctrl.rotate_sense == $past(insn[10]))
    else $error("shift bits wrong");
  a_flush_clr: assert property (tk && op[6:3] == 4'h7 && op[1:0] == 2'h0 |=> ctrl.flush_clear == $past(insn[27]))
    else $error("flush clear wrong");
  a_trap_emu: assert property (tk && op == 7'h01 |=> ctrl.emu_trap == $past(insn[27]))
    else $error("emulation bit wrong");
  a_float_prec: assert property (tk && op[6:2] == 5'h1C |=> ctrl.result_precision == $past(insn[10:9])
    && ctrl.second_operand_precision == $past(insn[8:7]) && ctrl.first_operand_precision == $past(insn[6:5]))
    else $error("float precision wrong");
  a_round_mode: assert property (tk && op == 7'h74 |=> ctrl.round_select == $past(insn[8:7]))
    else $error("round mode wrong");
  a_vec_prec: assert property (tk && op == 7'h60 |=> ctrl.vec_dp == $past(insn[7]) && ctrl.par_dp == $past(insn[9]))
    else $error("vector precision wrong");
  a_bad_format: assert property (take && insn[21:20] != 2'h3 |=> ctrl.illegal)
    else $error("bad format not flagged");
  a_bad_ones: assert property (take && op == 7'h7F |=> ctrl.illegal && ctrl.const_operands == $past(insn[12]))
    else $error("all-ones opcode wrong");
endmodule
bind mrod_decoder mrod_decoder_asserts u_chk (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
  .imm_word_valid(imm_word_valid), .imm_word(imm_word), .insn_ready(insn_ready), .ctrl_valid(ctrl_valid), .ctrl(ctrl));

// *** mrod_decoder_bench.sv ***
// Self-checking bench for the opcode field decoder
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module mrod_decoder_bench
  import mrod_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        insn_valid = 1'b0;
  logic [31:0] insn       = 32'h0;
  logic        prompt     = 1'b1;
  logic [2:0]  delay      = 3'h0;
  logic [31:0] value      = 32'h0;
  logic        imm_word_valid;
  logic        insn_ready;
  logic        ctrl_valid;
  logic [31:0] imm_word;
  mrod_ctrl_t  ctrl;
  int          error_cnt  = 0;
  int          compares   = 0;
  mrod_decoder dut (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn), .imm_word_valid(imm_word_valid),
    .imm_word(imm_word), .insn_ready(insn_ready), .ctrl_valid(ctrl_valid), .ctrl(ctrl));
  mrod_fetch_model fm (.clk(clk), .prompt(prompt), .delay(delay), .value(value), .insn_valid(insn_valid),
    .insn(insn), .insn_ready(insn_ready), .imm_word_valid(imm_word_valid), .imm_word(imm_word));
  // Clock of 4 ns
  initial forever #2 clk = ~clk;
  // Word builder with reserved bits left zero
  function automatic logic [31:0] w(logic [6:0] op, logic [6:0] opt, logic l = 1'b0, logic [4:0] d = 5'h2);
    return {d, 5'h9, 2'h3, op, l, opt, 5'h2};
  endfunction
  // One word taken, answer pulse expected
  task automatic dec(logic [31:0] word);
    @(negedge clk);
    insn_valid = 1'b1;
    insn = word;
    @(posedge clk);
    @(negedge clk);
    insn_valid = 1'b0;
    `CHK("ctrl_valid", 1'b1, ctrl_valid)
  endtask
  // Loads and stores over all sizes
  task automatic t_memory();
    for (int i = 0; i < 8; i++) begin
      dec(w({2'h1, i[2], 1'b0, i[0], i[1:0]}, {i[1], ~i[0], 5'h0}));
      `CHK("size", i[1:0], ctrl.access_size_field)
      `CHK("writeback", i[0], ctrl.writeback)
      `CHK("scale", i[1], ctrl.scale)
      `CHK("scale_shift", {1'b0, i[1] ? i[1:0] : 2'h0}, ctrl.scale_shift)
      `CHK("direct", ~i[0], ctrl.direct)
      `CHK("class", i[2] ? MROD_C_STORE : MROD_C_LOAD, ctrl.op_class)
    end
  endtask
  // All eight shift variants
  task automatic t_shift();
    for (int v = 0; v < 8; v++) begin
      dec(w({4'h1, v[2:0]}, {v[0], v[1], 5'h0}));
      `CHK("mask_mode", v / 3, ctrl.mask_mode)
      `CHK("fill_mode", v % 3, ctrl.fill_mode)
      `CHK("mask_invert", v[0], ctrl.mask_invert)
      `CHK("rotate_sense", v[1], ctrl.rotate_sense)
    end
  endtask
  // All ten logic forms
  task automatic t_logic();
    logic [6:0] ops [10] = '{7'h11, 7'h12, 7'h14, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1B, 7'h1D, 7'h1E};
    int kind [10] = '{0, 0, 0, 2, 1, 0, 3, 1, 1, 1};
    int nf [10] = '{0, 1, 1, 0, 0, 2, 0, 1, 1, 2};
    for (int k = 0; k < 10; k++) begin
      dec(w(ops[k], 7'h0));
      `CHK("logic_op", kind[k], ctrl.logic_op)
      `CHK("inversions", nf[k], ctrl.invert_src1 + ctrl.invert_src2)
    end
  endtask
  // Trap, flush, float, vector, branch and bad encodings
  task automatic t_misc();
    logic [6:0]  cop [12] = '{7'h05, 7'h0B, 7'h1E, 7'h44, 7'h4C, 7'h50, 7'h5A, 7'h65, 7'h75, 7'h47, 7'h52, 7'h76};
    mrod_class_t cls [12] = '{MROD_C_CTRL, MROD_C_SHIFT, MROD_C_LOGIC, MROD_C_BRANCH, MROD_C_BRANCH, MROD_C_INT,
      MROD_C_INT, MROD_C_VEC, MROD_C_FP, MROD_C_ILLEGAL, MROD_C_ILLEGAL, MROD_C_ILLEGAL};
    for (int e = 0; e < 2; e++) begin
      dec(w(7'h01, 7'h0, 1'b0, {4'h0, e[0]}) & 32'h083F_F01F);
      `CHK("emu_trap", e[0], ctrl.emu_trap)
      `CHK("illegal", 1'b0, ctrl.illegal)
    end
    dec(w(7'h3C, 7'h0, 1'b0, 5'h1));
    `CHK("flush_clear", 1'b1, ctrl.flush_clear)
    `CHK("flush_wb", 1'b1, ctrl.writeback)
    `CHK("flush_class", MROD_C_FLUSH, ctrl.op_class)
    for (int r = 0; r < 4; r++) begin
      dec(w(7'h74, {3'h0, r[1:0], 2'h0}) & 32'hF83F_FFFF);
      `CHK("round", r[1:0], ctrl.round_select)
    end
    dec(w(7'h70, 7'h1B));
    `CHK("prec", 6'h1B, {ctrl.result_precision, ctrl.second_operand_precision, ctrl.first_operand_precision})
    `CHK("regs", {5'h2, 5'h9, 5'h2}, {ctrl.dest, ctrl.src2, ctrl.src1})
    for (int j = 0; j < 2; j++) begin
      dec(w(7'h60, j ? 7'h22 : 7'h14));
      `CHK("vec_dp", ~j[0], ctrl.vec_dp)
      `CHK("par_dp", ~j[0], ctrl.par_dp)
      `CHK("par_mem", j[0], ctrl.par_mem)
      `CHK("par_reg", 5'h2, ctrl.par_reg)
      dec(w(j ? 7'h6E : 7'h66, j ? 7'h48 : 7'h0));
      `CHK("acc", {j[0], j[0], 1'b1}, {ctrl.acc_sel, ctrl.acc_zero, ctrl.accumulate})
    end
    dec(w(7'h41, 7'h0) & 32'hF83F_FFFF);
    `CHK("annul", 1'b1, ctrl.annul)
    dec(32'h0);
    `CHK("bad_format", 1'b1, ctrl.illegal)
    dec(w(7'h07, 7'h0));
    `CHK("undefined", 1'b1, ctrl.illegal)
    dec(w(7'h7F, 7'h0) & 32'h003F_F000);
    `CHK("ones_plain", 2'h2, {ctrl.illegal, ctrl.const_operands})
    for (int c = 0; c < 12; c++) begin
      dec(w(cop[c], 7'h0));
      `CHK("class", cls[c], ctrl.op_class)
    end
    dec({10'h000, 2'h3, 7'h7E, 13'h0000});
    `CHK("bit_class", MROD_C_BIT, ctrl.op_class)
  endtask
  // Long form prompt and late, refusal while waiting, back to back
  task automatic t_long();
    value = 32'hA5C30F96;
    dec(w(7'h58, 7'h0, 1'b1));
    `CHK("imm", 32'hA5C30F96, ctrl.imm)
    `CHK("imm_valid", 1'b1, ctrl.imm_valid)
    dec(w(7'h7F, 7'h0, 1'b1) & 32'h003F_F000);
    `CHK("ones_const", 2'h3, {ctrl.illegal, ctrl.const_operands})
    prompt = 1'b0;
    delay = 3'h2;
    value = 32'h5A3CF069;
    @(negedge clk);
    insn_valid = 1'b1;
    insn = w(7'h58, 7'h0, 1'b1);
    @(posedge clk);
    @(negedge clk);
    `CHK("insn_ready", 1'b0, insn_ready)
    insn = w(7'h01, 7'h0) & 32'h083F_F01F;
    for (int n = 0; n < 8 && ctrl_valid !== 1'b1; n++) @(negedge clk);
    `CHK("late_imm", 32'h5A3CF069, ctrl.imm)
    `CHK("late_op", 7'h58, ctrl.opcode)
    @(negedge clk);
    `CHK("after_op", 7'h01, ctrl.opcode)
    insn = w(7'h16, 7'h0);
    @(negedge clk);
    insn_valid = 1'b0;
    `CHK("b2b", 8'h96, {ctrl_valid, ctrl.opcode})
  endtask
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    results();
  end
  // Reset, scenarios, reset again
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_memory();
    t_shift();
    t_logic();
    t_misc();
    t_long();
    rst = 1'b1;
    @(negedge clk);
    `CHK("reset", 3'h3, {ctrl_valid, ctrl == '0, insn_ready})
    rst = 1'b0;
    dec(w(7'h16, 7'h0));
    `CHK("after_reset", 7'h16, ctrl.opcode)
    results();
  end
  // Verdict
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
endmodule
